// *** rtl/apdp_display_port.sv ***
// asynchronous parallel display bus master, 80 and 68k styles
// assumes requests come from dma or slave side on i_sys_clk, display pins
// are driven straight from flops, the read bus is synchronised here
`timescale 1ns/1ps
`include "apdp_map.svh"
module apdp_display_port #(
  parameter int DW = `APDP_DATA_W,
  parameter int BW = `APDP_BE_W,
  parameter int TW = `APDP_TIME_W,
  parameter int LW = `APDP_LEN_W,
  parameter int ND = `APDP_NUM_DISP
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset,
  // configuration
  input  wire apdp_pkg::bus_style_t   i_bus_style,
  input  wire apdp_pkg::access_mode_t i_access_mode,
  input  wire logic                   i_byte_enable_on,
  input  wire logic [3:0]             i_pause_setting,
  input  wire logic [TW-1:0]          i_write_access_period,
  input  wire logic [TW-1:0]          i_read_access_period,
  input  wire logic [TW-1:0]          i_write_strobe_fall_point,
  input  wire logic [TW-1:0]          i_write_strobe_rise_point,
  input  wire logic [TW-1:0]          i_read_strobe_fall_point,
  input  wire logic [TW-1:0]          i_read_strobe_rise_point,
  input  wire logic [TW-1:0]          i_read_sample_point,
  input  wire logic [TW-1:0]          i_fast_clock_period_setting,
  // request stream from dma or slave side
  input  wire logic                   i_req_valid,
  input  wire logic                   i_req_from_dma,
  input  wire logic [LW-1:0]          i_dma_burst_len,
  input  wire logic [2:0]             i_slave_hburst,
  input  wire logic                   i_req_write,
  input  wire logic [$clog2(ND)-1:0]  i_req_disp,
  input  wire logic [DW-1:0]          i_req_data,
  input  wire logic [BW-1:0]          i_req_be,
  input  wire logic                   i_req_last,
  output logic                        o_req_ready,
  output logic                        o_rd_valid,
  output logic [DW-1:0]               o_rd_data,
  output logic                        o_busy,
  // display pins
  input  wire logic [DW-1:0]          i_disp_data,
  output logic [DW-1:0]               o_disp_data,
  output logic                        o_disp_data_oe,
  output logic [BW-1:0]               o_disp_byte_en_n,
  output logic [ND-1:0]               o_display_chip_select_n,
  output logic [ND-1:0]               o_display_write_strobe_n,
  output logic [ND-1:0]               o_display_read_strobe_n,
  output logic                        o_display_burst_clock
);
  import apdp_pkg::*;

  port_state_t     st_q;
  logic [LW-1:0]   left_q;
  logic            wr_q;
  logic            dir_chg_q;
  logic [$clog2(ND)-1:0] disp_q;
  logic            disp_valid_q;
  logic [DW-1:0]   dat_q;
  logic [BW-1:0]   be_q;
  logic            last_q;
  logic            in_burst_q;
  logic [DW-1:0]   rd_s1_q;
  logic [DW-1:0]   rd_s2_q;
  logic            pause_start;
  logic            pause_busy;
  logic            ph_strobe;
  logic            ph_sample;
  logic            ph_last;
  logic            run_ph;
  logic            cs_style;
  logic            is68;
  logic [LW-1:0]   req_len;
  logic [TW-1:0]   per_w;
  logic [TW-1:0]   fall_w;
  logic [TW-1:0]   rise_w;
  logic            take;

  // style decode
  assign cs_style = (i_bus_style == BUS_80_CS) || (i_bus_style == BUS_68_CS);
  assign is68     = (i_bus_style == BUS_68_CS) ||
                    (i_bus_style == BUS_68_STROBE);

  // burst length: dma count or slave burst code
  always_comb begin
    req_len = LW'(1);
    if (i_req_from_dma) begin
      req_len = (i_dma_burst_len == '0) ? LW'(1) : i_dma_burst_len;
    end else begin
      case (i_slave_hburst)
        3'h2, 3'h3: req_len = LW'(4);
        3'h4, 3'h5: req_len = LW'(8);
        3'h6, 3'h7: req_len = LW'(16);
        3'h1:       req_len = LW'(0); // undefined incr, ends on i_req_last
        default:    req_len = LW'(1);
      endcase
    end
  end

  // read and write timing sets, access period stretched by the fast period setting
  // the sum is cut to the phase width on purpose, settings stay small
  assign per_w  = TW'((wr_q ? i_write_access_period : i_read_access_period)
                  + i_fast_clock_period_setting);
  assign fall_w = wr_q ? i_write_strobe_fall_point : i_read_strobe_fall_point;
  assign rise_w = wr_q ? i_write_strobe_rise_point : i_read_strobe_rise_point;
  assign run_ph = (st_q == ST_ACC) || (st_q == ST_GAP);

  apdp_phase_gen #(
    .TW (TW)
  ) u_phase (
    .i_sys_clk   (i_sys_clk),
    .i_reset     (i_reset),
    .i_run       (run_ph),
    .i_period    (per_w),
    .i_fall      (fall_w),
    .i_rise      (rise_w),
    .i_sample    (i_read_sample_point),
    .o_strobe_on (ph_strobe),
    .o_sample    (ph_sample),
    .o_last      (ph_last)
  );

  apdp_pause_timer #(
    .PW (4)
  ) u_pause (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_start   (pause_start),
    .i_setting (i_pause_setting),
    .o_busy    (pause_busy)
  );

  // a new burst, or a word for another display, waits out the pause
  assign take = (st_q == ST_IDLE) && i_req_valid && !pause_busy;

  // pause starts once a burst ends, and on a display change inside a
  // burst; a fresh burst already waited out the end-of-burst pause, so
  // a second one there would stretch the gap past its range
  assign pause_start = ((st_q == ST_DONE)) ||
                       (take && disp_valid_q && (i_req_disp != disp_q) &&
                        in_burst_q);

  // main sequencer
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (i_req_valid && !pause_busy) begin
            if (disp_valid_q && (i_req_disp != disp_q) && in_burst_q) begin
              st_q <= ST_PAUSE;
            end else begin
              st_q <= ST_ACC;
            end
          end
        end
        ST_PAUSE: if (!pause_busy) st_q <= ST_ACC;
        ST_ACC: begin
          if (ph_last) begin
            if (i_access_mode == MODE_SINGLE) begin
              st_q <= ST_GAP;
            end else if (last_q) begin
              st_q <= ST_DONE;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_GAP: if (ph_last) st_q <= last_q ? ST_DONE : ST_IDLE;
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // word capture and burst bookkeeping
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wr_q         <= 1'b1;
      dir_chg_q    <= 1'b0;
      disp_q       <= '0;
      disp_valid_q <= 1'b0;
      dat_q        <= '0;
      be_q         <= '0;
      last_q       <= 1'b0;
      left_q       <= '0;
      in_burst_q   <= 1'b0;
    end else begin
      if (st_q == ST_DONE) begin
        in_burst_q <= 1'b0;
      end
      if (take) begin
        dir_chg_q    <= in_burst_q && (wr_q != i_req_write);
        wr_q         <= i_req_write;
        disp_q       <= i_req_disp;
        disp_valid_q <= 1'b1;
        dat_q        <= i_req_data;
        be_q         <= i_byte_enable_on ? i_req_be : {BW{1'b1}};
        in_burst_q   <= 1'b1;
        if (!in_burst_q) begin
          left_q <= req_len - LW'(1);
          last_q <= (req_len == LW'(1)) || i_req_last;
        end else begin
          left_q <= left_q - LW'(1);
          last_q <= (left_q == LW'(1)) || i_req_last;
        end
      end
    end
  end

  // request handshake
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_req_ready <= 1'b0;
      o_busy      <= 1'b0;
    end else begin
      o_req_ready <= take;
      o_busy      <= (st_q != ST_IDLE) || pause_busy;
    end
  end

  // two-flop synchroniser on the display read bus
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rd_s1_q <= '0;
      rd_s2_q <= '0;
    end else begin
      rd_s1_q <= i_disp_data;
      rd_s2_q <= rd_s1_q;
    end
  end

  // read data capture at the programmed sample point
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end else begin
      o_rd_valid <= (st_q == ST_ACC) && !wr_q && ph_sample;
      if ((st_q == ST_ACC) && !wr_q && ph_sample) begin
        o_rd_data <= rd_s2_q;
      end
    end
  end

  // pin drive: select and strobe lines idle high outside a burst, burst clock and data enable low
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_display_chip_select_n  <= {ND{1'b1}};
      o_display_write_strobe_n <= {ND{1'b1}};
      o_display_read_strobe_n  <= {ND{1'b1}};
      o_display_burst_clock    <= 1'b0;
      o_disp_data              <= '0;
      o_disp_data_oe           <= 1'b0;
      o_disp_byte_en_n         <= {BW{1'b1}};
    end else begin
      o_display_chip_select_n  <= {ND{1'b1}};
      o_display_write_strobe_n <= {ND{1'b1}};
      o_display_read_strobe_n  <= {ND{1'b1}};
      o_display_burst_clock    <= 1'b0;
      o_disp_byte_en_n         <= {BW{1'b1}};
      if (st_q == ST_ACC) begin
        o_disp_data      <= dat_q;
        o_disp_data_oe   <= wr_q;
        o_disp_byte_en_n <= ~be_q;
        case (i_access_mode)
          MODE_BURST_CLK: begin
            o_display_chip_select_n[disp_q] <= 1'b0;
            o_display_burst_clock           <= ph_strobe;
            // 80 style: wr/rd level marks direction; 68k: rd line is r/w
            if (is68) begin
              o_display_read_strobe_n[disp_q]  <= wr_q;
              o_display_write_strobe_n[disp_q] <= 1'b0;
            end else begin
              o_display_write_strobe_n[disp_q] <= !wr_q;
              o_display_read_strobe_n[disp_q]  <= wr_q;
            end
          end
          default: begin
            if (cs_style) begin
              o_display_chip_select_n[disp_q] <= !ph_strobe;
              if (is68) begin
                o_display_read_strobe_n[disp_q]  <= wr_q;
                o_display_write_strobe_n[disp_q] <= 1'b1;
              end else begin
                o_display_write_strobe_n[disp_q] <= !wr_q;
                o_display_read_strobe_n[disp_q]  <= wr_q;
              end
            end else begin
              o_display_chip_select_n[disp_q] <= 1'b0;
              if (is68) begin
                o_display_write_strobe_n[disp_q] <= !ph_strobe;
                o_display_read_strobe_n[disp_q]  <= wr_q;
              end else begin
                o_display_write_strobe_n[disp_q] <= !(ph_strobe && wr_q);
                o_display_read_strobe_n[disp_q]  <= !(ph_strobe && !wr_q);
              end
            end
          end
        endcase
      end else if (in_burst_q && (st_q != ST_GAP) && (st_q != ST_DONE) &&
                   (st_q != ST_PAUSE) &&
                   (i_access_mode != MODE_SINGLE)) begin
        // between words of one burst chip select or direction holds
        if (!cs_style || (i_access_mode == MODE_BURST_CLK)) begin
          o_display_chip_select_n[disp_q] <= 1'b0;
        end
        if (cs_style && !dir_chg_q) begin
          o_display_write_strobe_n[disp_q] <= is68 ? 1'b1 : !wr_q;
          o_display_read_strobe_n[disp_q]  <= wr_q;
        end
        o_disp_data_oe <= wr_q;
      end else begin
        o_disp_data_oe <= 1'b0;
      end
    end
  end
endmodule // apdp_display_port

// *** rtl/apdp_map.svh ***
// field widths, reset values and timing counts of the display port
// assumes inclusion by bare name from the package and design files
`ifndef APDP_MAP_SVH
`define APDP_MAP_SVH
`define APDP_DATA_W        16
`define APDP_BE_W          2
`define APDP_TIME_W        8
`define APDP_PAUSE_W       4
`define APDP_LEN_W         8
`define APDP_NUM_DISP      2
`define APDP_PAUSE_MIN     5'h04
`define APDP_PAUSE_MAX     5'h13
`define APDP_RST_PER       8'h08
`define APDP_RST_DOWN      8'h02
`define APDP_RST_UP        8'h06
`define APDP_RST_RDEN      8'h05
`define APDP_CLK_NS        8
`define APDP_SYS_MHZ       125
`endif

// *** rtl/apdp_pkg.sv ***
// types shared by the display port: bus styles, modes, controller states
// assumes apdp_map.svh sits on the include path
`include "apdp_map.svh"
package apdp_pkg;
  typedef enum logic [1:0] {
    BUS_80_CS     = 2'h0,
    BUS_80_STROBE = 2'h1,
    BUS_68_CS     = 2'h2,
    BUS_68_STROBE = 2'h3
  } bus_style_t;

  typedef enum logic [1:0] {
    MODE_BURST       = 2'h0,
    MODE_BURST_CLK   = 2'h1,
    MODE_SINGLE      = 2'h2,
    MODE_RSVD        = 2'h3
  } access_mode_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_PAUSE = 5'b00010,
    ST_ACC   = 5'b00100,
    ST_GAP   = 5'b01000,
    ST_DONE  = 5'b10000
  } port_state_t;
endpackage

// *** rtl/apdp_pause_timer.sv ***
// inter-burst pause counter in fast clock cycles
// assumes the setting is clamped by the caller's range check here too
`timescale 1ns/1ps
`include "apdp_map.svh"
module apdp_pause_timer #(
  parameter int PW = `APDP_PAUSE_W
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset,
  input  wire logic          i_start,
  input  wire logic [PW-1:0] i_setting,
  output logic               o_busy
);
  logic [4:0] cnt_q;
  logic [4:0] load_w;

  // setting 0..15 maps onto 4..19 cycles
  assign load_w = 5'(i_setting) + `APDP_PAUSE_MIN - 5'h01;

  // counts down to zero, busy while non-zero
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cnt_q <= 5'h00;
    end else if (i_start) begin
      cnt_q <= load_w;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end

  assign o_busy = i_start || (cnt_q != 5'h00);
endmodule // apdp_pause_timer

// *** rtl/apdp_phase_gen.sv ***
// access phase counter: one display interface clock split into fast cycles
// assumes period, fall, rise and sample points are stable during an access
`timescale 1ns/1ps
`include "apdp_map.svh"
module apdp_phase_gen #(
  parameter int TW = `APDP_TIME_W
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset,
  input  wire logic          i_run,
  input  wire logic [TW-1:0] i_period,
  input  wire logic [TW-1:0] i_fall,
  input  wire logic [TW-1:0] i_rise,
  input  wire logic [TW-1:0] i_sample,
  output logic               o_strobe_on,
  output logic               o_sample,
  output logic               o_last
);
  logic [TW-1:0] ph_q;
  logic [TW-1:0] per_w;

  // a period of zero would never end, treat it as one
  assign per_w = (i_period == '0) ? TW'(1) : i_period;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !i_run || o_last) begin
      ph_q <= '0;
    end else begin
      ph_q <= ph_q + TW'(1);
    end
  end

  assign o_last      = i_run && (ph_q == per_w - TW'(1));
  assign o_strobe_on = i_run && (ph_q >= i_fall) && (ph_q < i_rise);
  assign o_sample    = i_run && (ph_q == i_sample);
endmodule // apdp_phase_gen

// *** verification/apdp_display_port_properties.sv ***
// assertions on the display port pins and its request handshake
// assumes write periods of 8 or more, modes changed only while idle
`timescale 1ns/1ps
module apdp_display_port_properties #(
  parameter int DW = 16,
  parameter int ND = 2
) (
  input wire logic                   i_sys_clk,
  input wire logic                   i_reset,
  input wire apdp_pkg::bus_style_t   i_bus_style,
  input wire apdp_pkg::access_mode_t i_access_mode,
  input wire logic                   o_req_ready,
  input wire logic [DW-1:0]          o_disp_data,
  input wire logic                   o_disp_data_oe,
  input wire logic [ND-1:0]          o_display_chip_select_n,
  input wire logic [ND-1:0]          o_display_write_strobe_n,
  input wire logic [ND-1:0]          o_display_read_strobe_n,
  input wire logic                   o_display_burst_clock
);
  import apdp_pkg::*;
  logic [ND-1:0] cs, wr, rd;
  logic          s80, any_cs;
  // active-high views, so the properties read like the timing
  assign cs     = ~o_display_chip_select_n;
  assign wr     = ~o_display_write_strobe_n;
  assign rd     = ~o_display_read_strobe_n;
  assign any_cs = |cs;
  assign s80    = i_bus_style == BUS_80_STROBE;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  a_reset_idle: assert property (
    $fell(i_reset) |-> !any_cs && wr == '0 && rd == '0 && !o_disp_data_oe
    && !o_display_burst_clock) else $error("pins active after reset");
  a_ready_pulse: assert property (
    o_req_ready |=> !o_req_ready) else $error("ready held too long");
  a_one_display: assert property (
    $onehot0(cs)) else $error("two displays selected");
  a_strobe_in_cs: assert property (
    s80 |-> (wr & ~cs) == '0 && (rd & ~cs) == '0)
    else $error("strobe outside select");
  a_bclk_in_cs: assert property (
    o_display_burst_clock |-> any_cs && i_access_mode == MODE_BURST_CLK)
    else $error("burst clock outside a clocked burst");
  a_write_drives: assert property (
    s80 && wr != '0 |-> o_disp_data_oe) else $error("write without data");
  a_read_floats: assert property (
    s80 && rd != '0 |-> !o_disp_data_oe) else $error("data driven in read");
  a_data_hold: assert property (
    s80 && i_access_mode != MODE_BURST_CLK && wr != '0 && $past(wr) != '0
    |-> $stable(o_disp_data)) else $error("data moved under strobe");
  // cs-sampled styles may keep strobes through the cs release, so cs only
  a_single_gap: assert property (
    i_access_mode == MODE_SINGLE && $fell(any_cs) |-> (!any_cs) [*8])
    else $error("single access gap too short");
endmodule // apdp_display_port_properties

bind apdp_display_port apdp_display_port_properties #(.DW(DW), .ND(ND))
  i_props (.i_sys_clk, .i_reset, .i_bus_style, .i_access_mode,
  .o_req_ready, .o_disp_data, .o_disp_data_oe, .o_display_chip_select_n,
  .o_display_write_strobe_n, .o_display_read_strobe_n,
  .o_display_burst_clock);

// *** verification/apdp_display_model.sv ***
// behavioural display on the far side of the parallel port
// assumes two displays and words landing as the qualifier releases
`timescale 1ns/1ps
module apdp_display_model #(
  parameter logic [15:0] RD_WORD = 16'h5a3c
) (
  input  wire logic        i_clk,
  input  wire logic [1:0]  i_style,
  input  wire logic        i_slow,
  input  wire logic [1:0]  i_cs_n,
  input  wire logic [1:0]  i_wr_n,
  input  wire logic [1:0]  i_rd_n,
  input  wire logic [15:0] i_data,
  output logic      [15:0] o_data,
  output logic      [15:0] o_last,
  output int               o_words
);
  logic p_cs, p_wr, p_rd, rdg, tk;
  int   rlen;
  // 80 style reads on a low strobe, 68k on r/w low under select
  assign rdg = i_style[1] ? |(~i_cs_n & ~i_rd_n) : |(~i_rd_n);
  // cs styles latch on select release, strobe styles on strobe release
  assign tk = (i_style[0] ? !p_wr && &i_wr_n : !p_cs && &i_cs_n) &&
              (i_style[1] ? p_rd : !p_wr);
  initial begin
    {o_data, o_last, o_words, rlen} = '0;
    {p_cs, p_wr, p_rd} = 3'h7;
  end
  // released bus toggles, so a stale word never looks valid
  always @(posedge i_clk) begin
    if (tk) o_last <= i_data;
    if (tk) o_words <= o_words + 1;
    rlen <= rdg ? rlen + 1 : 0;
    o_data <= rdg && rlen >= 32'(i_slow) ? RD_WORD : ~o_data;
    p_cs <= &i_cs_n;
    p_wr <= &i_wr_n;
    p_rd <= &i_rd_n;
  end
endmodule // apdp_display_model

// *** verification/async_parallel_display_port_bench.sv ***
// self-checking bench for the parallel display port with a display model
// assumes one 125 MHz clock and the design's default widths
`timescale 1ns/1ps
module async_parallel_display_port_bench;
  import apdp_pkg::*;
  localparam logic [15:0] RD_WORD = 16'h5a3c;
  bus_style_t   i_bus_style;
  access_mode_t i_access_mode;
  logic         i_sys_clk, i_reset, i_byte_enable_on, i_req_valid, slow;
  logic         i_req_from_dma, i_req_write, i_req_last, p_cs, p_wr, p_bk;
  logic         o_req_ready, o_rd_valid, o_busy, o_disp_data_oe;
  logic         o_display_burst_clock;
  logic [3:0]   i_pause_setting;
  logic [7:0]   i_write_access_period, i_read_access_period;
  logic [7:0]   i_write_strobe_fall_point, i_write_strobe_rise_point;
  logic [7:0]   i_read_strobe_fall_point, i_read_strobe_rise_point;
  logic [7:0]   i_read_sample_point, i_fast_clock_period_setting;
  logic [7:0]   i_dma_burst_len;
  logic [2:0]   i_slave_hburst;
  logic [0:0]   i_req_disp;
  logic [1:0]   i_req_be, o_disp_byte_en_n, o_display_chip_select_n;
  logic [1:0]   o_display_write_strobe_n, o_display_read_strobe_n;
  logic [15:0]  i_req_data, i_disp_data, o_rd_data, o_disp_data;
  logic [15:0]  m_last, dbase;
  int           n_fail, n_checks, m_words, n_csf, n_wrf, n_bck;
  int           gap, last_gap, wr_cnt, wr_len;
  wire          csa = ~&o_display_chip_select_n;
  wire          wra = ~&o_display_write_strobe_n;

  apdp_display_port i_dut (.i_sys_clk, .i_reset, .i_bus_style,
    .i_access_mode, .i_byte_enable_on, .i_pause_setting,
    .i_write_access_period, .i_read_access_period,
    .i_write_strobe_fall_point, .i_write_strobe_rise_point,
    .i_read_strobe_fall_point, .i_read_strobe_rise_point,
    .i_read_sample_point, .i_fast_clock_period_setting, .i_req_valid,
    .i_req_from_dma, .i_dma_burst_len, .i_slave_hburst, .i_req_write,
    .i_req_disp, .i_req_data, .i_req_be, .i_req_last, .o_req_ready,
    .o_rd_valid, .o_rd_data, .o_busy, .i_disp_data, .o_disp_data,
    .o_disp_data_oe, .o_disp_byte_en_n, .o_display_chip_select_n,
    .o_display_write_strobe_n, .o_display_read_strobe_n,
    .o_display_burst_clock);
  apdp_display_model #(.RD_WORD(RD_WORD)) i_disp (.i_clk(i_sys_clk),
    .i_style(i_bus_style), .i_slow(slow), .i_cs_n(o_display_chip_select_n),
    .i_wr_n(o_display_write_strobe_n), .i_rd_n(o_display_read_strobe_n),
    .i_data(o_disp_data), .o_data(i_disp_data), .o_last(m_last),
    .o_words(m_words));

  always #4 i_sys_clk = ~i_sys_clk;

  // edge counts, strobe width and select gap seen on the pins
  always @(posedge i_sys_clk) begin
    if (csa && !p_cs) n_csf++;
    if (csa && !p_cs) last_gap = gap;
    if (wra && !p_wr) n_wrf++;
    if (!wra && p_wr) wr_len = wr_cnt;
    if (o_display_burst_clock && !p_bk) n_bck++;
    gap = csa ? 0 : gap + 1;
    wr_cnt = wra ? wr_cnt + 1 : 0;
    p_cs = csa;
    p_wr = wra;
    p_bk = o_display_burst_clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // style and mode only move while the port is idle
  task automatic cfg(input int s, input int m);
    @(negedge i_sys_clk);
    i_bus_style = bus_style_t'(s);
    i_access_mode = access_mode_t'(m);
    i_byte_enable_on = s[0];
    {n_csf, n_wrf, n_bck} = '0;
  endtask

  // one burst, each word held until ready; idle waits out the pause
  task automatic xfer(input int n, input logic wr, dma, input logic [0:0] d,
                      input logic idle);
    int k;
    for (int i = 0; i < n; i++) begin
      @(negedge i_sys_clk);
      {i_req_valid, i_req_write} = {1'b1, wr};
      {i_req_from_dma, i_req_disp} = {dma, d};
      i_req_last = i == n - 1;
      i_dma_burst_len = 8'(n);
      i_req_data = dbase + 16'(i);
      i_req_be = 2'(i + 1);
      k = 0;
      @(posedge i_sys_clk);
      while (o_req_ready !== 1'b1 && k < 300) begin
        @(posedge i_sys_clk);
        k++;
      end
      chk(32'(k < 300), 1);
    end
    @(negedge i_sys_clk);
    i_req_valid = 1'b0;
    k = 0;
    while (!wr && o_rd_valid !== 1'b1 && k < 300) begin
      @(posedge i_sys_clk);
      k++;
    end
    if (!wr) chk(32'(o_rd_data), 32'(RD_WORD));
    k = 0;
    while (idle && o_busy !== 1'b0 && k < 300) begin
      @(posedge i_sys_clk);
      k++;
    end
    if (idle) chk(32'(k < 300), 1);
    // longest pause is 19 cycles
    if (idle) repeat (24) @(posedge i_sys_clk);
  endtask

  task automatic t_styles;
    int w0;
    for (int s = 0; s < 4; s++) begin
      cfg(s, 0);
      dbase = 16'h3c00 + 16'(s * 16);
      w0 = m_words;
      xfer(2, 1'b1, 1'b1, 1'b0, 1'b1);
      chk(m_words - w0, 2);
      chk(m_last, dbase + 16'h1);
    end
    $display("test styles done");
  endtask

  // burst, clocked burst and single access for both 80 types
  task automatic t_bursts;
    int w0;
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 2; s++) begin
        cfg(s, m);
        i_slave_hburst = 3'h3;
        i_write_strobe_fall_point = 8'(1 + m);
        w0 = m_words;
        xfer(4, 1'b1, s[0], 1'b0, 1'b1);
        chk(n_csf, (m == 2 || m + s == 0) ? 4 : 1);
        chk(n_bck, m == 1 ? 4 : 0);
        if (m != 1) chk(n_wrf, (m == 2 || s == 1) ? 4 : 1);
        if (m != 1) chk(m_words - w0, 4);
        if (m == 0 && s == 1) chk(wr_len, 5);
        chk({o_display_chip_select_n, o_display_burst_clock}, 3'h6);
      end
    end
    $display("test bursts done");
  endtask

  task automatic t_read;
    for (int s = 0; s < 4; s++) begin
      cfg(s, 2);
      slow = s[1];
      i_read_access_period = 8'(10 + s);
      i_read_sample_point = 8'(6 + s[0]);
      xfer(1, 1'b0, 1'b1, 1'(s[0]), 1'b1);
    end
    $display("test reads done");
  endtask

  // back-to-back bursts to the same and to the other display
  task automatic t_pause;
    for (int p = 0; p < 16; p += 15) begin
      for (int d = 0; d < 2; d++) begin
        cfg(1, 0);
        i_pause_setting = 4'(p);
        xfer(1, 1'b1, 1'b1, 1'b0, 1'b0);
        xfer(1, 1'b1, 1'b1, 1'(d), 1'b1);
        chk(32'(last_gap >= p + 4 && last_gap <= p + 12), 1);
      end
    end
    $display("test pause done");
  endtask

  // run takes under two thousand cycles; this cuts a hang short
  initial begin
    #(8 * 20000);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end

  initial begin
    i_sys_clk = 1'b0;
    i_reset = 1'b1;
    {i_req_valid, i_req_from_dma, i_req_write, i_req_last, slow} = '0;
    {p_cs, p_wr, p_bk, i_byte_enable_on} = '0;
    {n_fail, n_checks, n_csf, n_wrf, n_bck, gap, last_gap} = '0;
    {wr_cnt, wr_len} = '0;
    i_bus_style = BUS_80_CS;
    i_access_mode = MODE_BURST;
    {i_pause_setting, i_slave_hburst, i_req_disp, i_req_be} = '0;
    {i_dma_burst_len, i_req_data, dbase} = '0;
    {i_write_access_period, i_read_access_period} = 16'h080a;
    {i_write_strobe_fall_point, i_write_strobe_rise_point} = 16'h0206;
    {i_read_strobe_fall_point, i_read_strobe_rise_point} = 16'h0108;
    {i_read_sample_point, i_fast_clock_period_setting} = 16'h0600;
    repeat (6) @(negedge i_sys_clk);
    i_reset = 1'b0;
    chk({o_display_chip_select_n, o_display_write_strobe_n,
         o_display_read_strobe_n, o_display_burst_clock, o_disp_data_oe,
         o_req_ready}, 9'h1f8);
    $display("test reset done");
    t_styles;
    t_bursts;
    t_read;
    t_pause;
    end_sim;
  end
endmodule // async_parallel_display_port_bench
